//--- verilog/mads_pkg.sv
// Shared constants and types for the auto setup and direct drive block
package mads_pkg;
   // Operating mode codes
   localparam logic [7:0] OPMODE_NONE = 8'h00;
   localparam logic [7:0] OPMODE_AUTOSETUP = 8'hfe;
   localparam logic [7:0] OPMODE_VELOCITY = 8'h02;
   localparam logic [7:0] OPMODE_CLKDIR = 8'hff;
   // Control and status word bit positions
   localparam int CW_MODE_SPECIFIC_BIT = 4;
   localparam int SW_INDEX_FOUND_BIT = 10;
   localparam int SW_SETUP_DONE_BIT = 12;
   // Special drive configuration
   localparam logic [7:0] SPECIAL_ACTIVATE = 8'h02;
   localparam int MODE_CLOSED_BIT = 3;
   localparam int MODE_LOW_MAX_BIT = 0;
   localparam logic [1:0] KIND_CLKDIR = 2'h0;
   localparam logic [1:0] KIND_TEST = 2'h1;
   localparam logic [1:0] KIND_ANALOG = 2'h2;
   localparam logic [1:0] KIND_JOYSTICK = 2'h3;
   // Storage categories
   localparam logic [7:0] STORE_SUB_DRIVE = 8'h05;
   localparam logic [7:0] STORE_SUB_TUNE = 8'h06;
   // Speeds in rpm
   localparam logic [15:0] RPM_TEST = 16'h001e;
   localparam logic [15:0] RPM_MAX_HI = 16'h03e8;
   localparam logic [15:0] RPM_MAX_LO = 16'h0064;
   // Analog input: 12 bit converter, full scale in millivolts
   localparam int ADC_W = 12;
   localparam int FULL_SCALE_MV = 10000;
   localparam int DEAD_ZONE_MV = 20;
   localparam logic [11:0] ADC_FULL = 12'hfff;
   localparam logic [11:0] ADC_MID = 12'h7ff;
   localparam logic [11:0] DEAD_CNT =
      12'(DEAD_ZONE_MV * 4095 / FULL_SCALE_MV);
   // Parameter memory
   localparam int PMEM_AW = 3;
   localparam int PMEM_DW = 16;

   typedef enum logic [2:0] {
      PH_TYPE = 3'h0,
      PH_RES = 3'h1,
      PH_IND = 3'h2,
      PH_FLUX = 3'h3,
      PH_HALL = 3'h4
   } mads_phase_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_REQ = 3'h1,
      ST_WAIT = 3'h2,
      ST_DRIVE = 3'h3,
      ST_TUNE = 3'h4
   } mads_state_t;

   typedef struct packed {
      logic [7:0] activate;
      logic [3:0] mode;
   } mads_cfg_t;

   typedef struct packed {
      logic [7:0] op_mode;
      logic signed [15:0] target_vel;
      logic [15:0] vel_scale;
      logic [11:0] analog_offset;
      logic closed_loop;
      logic test_run;
      logic motion_en;
      logic step;
      logic dir;
   } mads_drive_t;
endpackage

//--- verilog/mads_param_mem.sv
// Small parameter store for auto setup results
`timescale 1ns/1ns
module mads_param_mem
   import mads_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic wr_en_i,
   input wire logic [PMEM_AW-1:0] wr_addr_i,
   input wire logic [PMEM_DW-1:0] wr_data_i,
   input wire logic [PMEM_AW-1:0] rd_addr_i,
   output logic [PMEM_DW-1:0] rd_data_o
);
   logic [PMEM_DW-1:0] mem_reg [2**PMEM_AW];
   logic [PMEM_DW-1:0] rd_reg;
   logic [PMEM_DW-1:0] rd_next;

   // Read data always comes out of a register
   always_comb begin
      rd_next = mem_reg[rd_addr_i];
   end

   // Array holds no reset; only the read register does
   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
      if (reset_i) begin
         rd_reg <= '0;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign rd_data_o = rd_reg;
endmodule

//--- verilog/mads_analog.sv
// Analog input to signed speed conversion
`timescale 1ns/1ns
module mads_analog
   import mads_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [ADC_W-1:0] adc_i,
   input wire logic joystick_i,
   input wire logic low_max_i,
   input wire logic dir_i,
   output logic signed [15:0] speed_o
);
   logic signed [15:0] speed_reg;
   logic signed [15:0] speed_next;
   logic [15:0] max_rpm;
   logic [11:0] mag;

   // Magnitude scaled linearly; constant divide keeps full scale exact
   function automatic logic [15:0] scale(input logic [11:0] m,
                                         input logic [15:0] mx,
                                         input logic [11:0] fs);
      logic [31:0] prod;
      prod = {20'h00000, m} * {16'h0000, mx};
      return 16'(prod / {20'h00000, fs});
   endfunction

   // Dead zones sit at zero volts or around the midpoint
   always_comb begin
      max_rpm = low_max_i ? RPM_MAX_LO : RPM_MAX_HI;
      mag = '0;
      speed_next = '0;
      if (joystick_i) begin
         mag = (adc_i > ADC_MID) ? adc_i - ADC_MID : ADC_MID - adc_i;
         if (mag > DEAD_CNT) begin // RULE22
            speed_next = $signed(scale(mag, max_rpm, ADC_MID));
            if (adc_i < ADC_MID) begin
               speed_next = -speed_next;
            end
         end
      end else begin
         mag = adc_i;
         if (mag > DEAD_CNT) begin // RULE20
            speed_next = $signed(scale(mag, max_rpm, ADC_FULL)); // RULE19
            if (dir_i) begin
               speed_next = -speed_next; // RULE19
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         speed_reg <= '0;
      end else begin
         speed_reg <= speed_next;
      end
   end

   assign speed_o = speed_reg;
endmodule

//--- verilog/mads_core.sv
// Auto setup sequencer and special direct drive mode control
//
// Summary of operation
// RULE1: Mode selection value fe selects auto setup and becomes active mode.
// RULE2: Setup only starts, and keeps running, while operation is enabled.
// RULE3: Rising mode specific bit in setup mode with drive enabled starts setup.
// RULE4: Status bit 12 set only after whole sequence, storage included, ends.
// RULE5: Status bit 10 shows whether an encoder index was seen.
// RULE6: Measure motor type, resistance, inductance and flux every run.
// RULE7: Hall transitions measured only when a Hall sensor is fitted.
// RULE8: Unequal winding inductances make flux invalid; sensorless disallowed.
// RULE9: Results written to parameter store, then saved as drive and tuning.
// RULE10: Host restarts device after setup; homing alone is not enough.
// RULE11: Activation value 2 enables special modes; mode value 00 to 0f.
// RULE12: Special configuration applies only after save and restart.
// RULE13: 00/01 clock-direction, 02/03 30 rpm test run, +08 closed loop.
// RULE14: 04/05 analog with direction, 06/07 joystick; odd means 100 rpm.
// RULE15: Enable input gates all motion in special modes.
// RULE16: Clock-direction mode switches operating mode and follows inputs.
// RULE17: Analog mode runs velocity mode with target from analog input.
// RULE18: Velocity scaling follows the selected maximum speed.
// RULE19: Full scale gives maximum speed; direction input sets sign.
// RULE20: Zero to 20 mV is a dead zone in normal analog mode.
// RULE21: Joystick midpoint is zero speed; offset set to midpoint.
// RULE22: Joystick speed signed about midpoint with 20 mV dead band.
// RULE23: Starting a new setup clears the setup complete flag.
`timescale 1ns/1ns
module mads_core
   import mads_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [7:0] op_mode_sel_i,
   input wire logic op_enabled_i,
   input wire logic [15:0] ctrl_word_i,
   input wire logic hall_fitted_i,
   input wire logic meas_ack_i,
   input wire logic [15:0] meas_data_i,
   input wire logic meas_index_i,
   input wire logic winding_mismatch_i,
   input wire logic store_ack_i,
   input wire logic [PMEM_AW-1:0] param_addr_i,
   input wire mads_cfg_t spec_cfg_i,
   input wire logic save_app_i,
   input wire logic restart_i,
   input wire logic enable_in_i,
   input wire logic clk_in_i,
   input wire logic dir_in_i,
   input wire logic [ADC_W-1:0] adc_i,
   output logic [15:0] status_word_o,
   output logic [7:0] active_op_mode_o,
   output logic meas_req_o,
   output logic [2:0] meas_sel_o,
   output logic store_req_o,
   output logic [7:0] store_sub_o,
   output logic [PMEM_DW-1:0] param_data_o,
   output logic sensorless_ok_o,
   output mads_drive_t drive_o
);
   mads_state_t state_reg, state_next;
   mads_phase_t phase_reg, phase_next;
   logic cw_bit_reg, cw_bit_next;
   logic done_reg, done_next;
   logic index_reg, index_next;
   logic mismatch_reg, mismatch_next;
   logic sensorless_reg, sensorless_next;
   logic meas_req_reg, meas_req_next;
   logic store_req_reg, store_req_next;
   logic [7:0] store_sub_reg, store_sub_next;
   logic [15:0] status_reg, status_next;
   logic start;
   mads_cfg_t saved_cfg_reg, saved_cfg_next;
   mads_cfg_t act_cfg_reg, act_cfg_next;
   mads_drive_t drive_reg, drive_next;
   logic special_on;
   logic [1:0] kind;
   logic signed [15:0] ana_speed;
   // Mode-specific bit edge with setup preselected and power enabled
   assign start = ctrl_word_i[CW_MODE_SPECIFIC_BIT] && !cw_bit_reg &&
      op_mode_sel_i == OPMODE_AUTOSETUP && op_enabled_i && // RULE2
      state_reg == ST_IDLE; // RULE3
   // Setup sequencer next state
   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      done_next = done_reg;
      index_next = index_reg;
      mismatch_next = mismatch_reg;
      sensorless_next = sensorless_reg;
      cw_bit_next = ctrl_word_i[CW_MODE_SPECIFIC_BIT];
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = ST_REQ;
               phase_next = PH_TYPE; // RULE6
               done_next = 1'b0; // RULE23
               index_next = 1'b0;
               mismatch_next = 1'b0;
            end
         end
         ST_REQ: begin
            state_next = ST_WAIT;
         end
         ST_WAIT: begin
            if (meas_ack_i) begin
               index_next = index_reg | meas_index_i; // RULE5
               if (phase_reg == PH_IND) begin
                  mismatch_next = winding_mismatch_i;
               end
               // Last phase is flux, or Hall when a sensor is fitted
               if (phase_reg == PH_HALL ||
                   (phase_reg == PH_FLUX && !hall_fitted_i)) begin // RULE7
                  state_next = ST_DRIVE;
               end else begin
                  state_next = ST_REQ;
                  phase_next = mads_phase_t'(phase_reg + 3'h1); // RULE6
               end
            end
         end
         ST_DRIVE: begin
            if (store_ack_i) begin
               state_next = ST_TUNE; // RULE9
            end
         end
         ST_TUNE: begin
            if (store_ack_i) begin
               state_next = ST_IDLE;
               done_next = 1'b1; // RULE4
               sensorless_next = !mismatch_reg; // RULE8
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Loss of operation enabled aborts the run without completion, unless it falls in the cycle of the final tuning store ack
      if (!op_enabled_i && state_reg != ST_IDLE) begin // RULE2
         state_next = ST_IDLE;
      end
      meas_req_next = state_reg == ST_REQ && state_next == ST_WAIT;
      store_req_next = state_next == ST_DRIVE || state_next == ST_TUNE;
      store_sub_next = state_next == ST_TUNE ?
         STORE_SUB_TUNE : STORE_SUB_DRIVE; // RULE9
      status_next = '0;
      status_next[SW_SETUP_DONE_BIT] = done_next; // RULE4
      status_next[SW_INDEX_FOUND_BIT] = index_next; // RULE5
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= ST_IDLE;
         phase_reg <= PH_TYPE;
         cw_bit_reg <= 1'b0;
         done_reg <= 1'b0;
         index_reg <= 1'b0;
         mismatch_reg <= 1'b0;
         sensorless_reg <= 1'b0;
         meas_req_reg <= 1'b0;
         store_req_reg <= 1'b0;
         store_sub_reg <= STORE_SUB_DRIVE;
         status_reg <= '0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         cw_bit_reg <= cw_bit_next;
         done_reg <= done_next;
         index_reg <= index_next;
         mismatch_reg <= mismatch_next;
         sensorless_reg <= sensorless_next;
         meas_req_reg <= meas_req_next;
         store_req_reg <= store_req_next;
         store_sub_reg <= store_sub_next;
         status_reg <= status_next;
      end
   end

   // Each measurement is taken over into its parameter entry at once
   mads_param_mem u_mem (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .wr_en_i(state_reg == ST_WAIT && meas_ack_i), // RULE9
      .wr_addr_i(phase_reg),
      .wr_data_i(meas_data_i),
      .rd_addr_i(param_addr_i),
      .rd_data_o(param_data_o)
   );

   // Saved configuration only becomes active on restart
   always_comb begin
      saved_cfg_next = save_app_i ? spec_cfg_i : saved_cfg_reg;
      act_cfg_next = restart_i ? saved_cfg_reg : act_cfg_reg; // RULE12
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         saved_cfg_reg <= '0;
         act_cfg_reg <= '0;
      end else begin
         saved_cfg_reg <= saved_cfg_next;
         act_cfg_reg <= act_cfg_next;
      end
   end
   assign special_on = act_cfg_reg.activate == SPECIAL_ACTIVATE; // RULE11
   assign kind = act_cfg_reg.mode[2:1];
   mads_analog u_analog (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .adc_i(adc_i),
      .joystick_i(kind == KIND_JOYSTICK), // RULE14
      .low_max_i(act_cfg_reg.mode[MODE_LOW_MAX_BIT]),
      .dir_i(dir_in_i),
      .speed_o(ana_speed)
   );
   // Drive outputs; without special modes the selected mode is passed on
   always_comb begin
      drive_next = '0;
      drive_next.op_mode = op_mode_sel_i; // RULE1
      drive_next.vel_scale = RPM_MAX_HI;
      if (special_on) begin
         drive_next.closed_loop = act_cfg_reg.mode[MODE_CLOSED_BIT]; // RULE13
         drive_next.motion_en = enable_in_i; // RULE15
         case (kind)
            KIND_CLKDIR: begin
               drive_next.op_mode = OPMODE_CLKDIR; // RULE16
               drive_next.step = clk_in_i && enable_in_i; // RULE16
               drive_next.dir = dir_in_i;
            end
            KIND_TEST: begin
               drive_next.op_mode = OPMODE_CLKDIR;
               drive_next.test_run = enable_in_i; // RULE13
               drive_next.dir = act_cfg_reg.mode[0];
               if (enable_in_i) begin
                  drive_next.target_vel = act_cfg_reg.mode[0] ?
                     -$signed(RPM_TEST) : $signed(RPM_TEST); // RULE13
               end
            end
            default: begin
               drive_next.op_mode = OPMODE_VELOCITY; // RULE17
               drive_next.vel_scale = act_cfg_reg.mode[MODE_LOW_MAX_BIT] ?
                  RPM_MAX_LO : RPM_MAX_HI; // RULE18
               drive_next.dir = ana_speed < 0;
               if (kind == KIND_JOYSTICK) begin
                  drive_next.analog_offset = ADC_MID; // RULE21
               end
               if (enable_in_i) begin
                  drive_next.target_vel = ana_speed; // RULE17
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         drive_reg <= '0;
      end else begin
         drive_reg <= drive_next;
      end
   end

   assign status_word_o = status_reg;
   assign active_op_mode_o = drive_reg.op_mode;
   assign meas_req_o = meas_req_reg;
   assign meas_sel_o = phase_reg;
   assign store_req_o = store_req_reg;
   assign store_sub_o = store_sub_reg;
   assign sensorless_ok_o = sensorless_reg;
   assign drive_o = drive_reg;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   property p_start;
      start |=> state_reg == ST_REQ && !status_reg[SW_SETUP_DONE_BIT];
   endproperty
   a_start: assert property (p_start) // RULE3
      else $error("setup did not start or done not cleared");
   property p_done;
      state_reg == ST_TUNE && store_ack_i && op_enabled_i
         |=> status_word_o[SW_SETUP_DONE_BIT];
   endproperty
   a_done: assert property (p_done) // RULE4
      else $error("done bit missing after tuning store");
   property p_done_only_end;
      $rose(status_word_o[SW_SETUP_DONE_BIT]) |-> $past(state_reg) == ST_TUNE;
   endproperty
   a_done_only_end: assert property (p_done_only_end) // RULE4
      else $error("done bit set before sequence end");
   property p_index;
      state_reg == ST_WAIT && meas_ack_i && meas_index_i
         |=> status_word_o[SW_INDEX_FOUND_BIT];
   endproperty
   a_index: assert property (p_index) // RULE5
      else $error("index found flag not reported");
   property p_hall_skip;
      meas_req_o && !hall_fitted_i |-> meas_sel_o != PH_HALL;
   endproperty
   a_hall_skip: assert property (p_hall_skip) // RULE7
      else $error("Hall measured without sensor");
   property p_sensorless;
      $rose(status_word_o[SW_SETUP_DONE_BIT]) && mismatch_reg
         |-> !sensorless_ok_o;
   endproperty
   a_sensorless: assert property (p_sensorless) // RULE8
      else $error("sensorless allowed despite winding mismatch");
   property p_store_sub;
      store_req_o && state_reg == ST_DRIVE |-> store_sub_o == STORE_SUB_DRIVE;
   endproperty
   a_store_sub: assert property (p_store_sub) // RULE9
      else $error("drive category not stored first");
   property p_cfg_hold;
      !restart_i |=> $stable(act_cfg_reg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) // RULE12
      else $error("special configuration changed without restart");
   property p_enable;
      special_on && !enable_in_i |=> !drive_o.motion_en &&
         drive_o.target_vel == 0 && !drive_o.step;
   endproperty
   a_enable: assert property (p_enable) // RULE15
      else $error("motion without enable input");
   property p_clkdir;
      special_on && kind == KIND_CLKDIR |=> active_op_mode_o == OPMODE_CLKDIR;
   endproperty
   a_clkdir: assert property (p_clkdir) // RULE16
      else $error("clock-direction mode not entered");
   property p_scale;
      special_on && kind[1] && act_cfg_reg.mode[MODE_LOW_MAX_BIT]
         |=> drive_o.vel_scale == RPM_MAX_LO;
   endproperty
   a_scale: assert property (p_scale) // RULE18
      else $error("velocity scale does not match 100 rpm");
   c_done: cover property ($rose(status_word_o[SW_SETUP_DONE_BIT]));
   c_index: cover property (status_word_o[SW_INDEX_FOUND_BIT] &&
      status_word_o[SW_SETUP_DONE_BIT]);
   c_joystick: cover property (special_on && kind == KIND_JOYSTICK &&
      drive_o.target_vel < 0);
   c_step: cover property (drive_o.step);
endmodule

//--- tb/mads_far_model.sv
// Far side model: measurement unit and parameter storage responder
`timescale 1ns/1ns
module mads_far_model
   import mads_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic slow_i,
   input wire logic index_en_i,
   input wire logic meas_req_i,
   input wire logic [2:0] meas_sel_i,
   input wire logic store_req_i,
   output logic meas_ack_o,
   output logic [15:0] meas_data_o,
   output logic meas_index_o,
   output logic store_ack_o
);
   logic [3:0] mcnt;
   logic [3:0] scnt;
   logic mbusy;

   // Answers after a short or long delay; outside the ack cycle the data
   // lines toggle, so a value read late never passes by luck
   always @(posedge clock_i) begin
      meas_ack_o <= 1'b0;
      store_ack_o <= 1'b0;
      meas_data_o <= ~meas_data_o;
      meas_index_o <= ~meas_index_o;
      if (reset_i) begin
         mbusy <= 1'b0;
         mcnt <= 4'h0;
         scnt <= 4'h1;
         meas_data_o <= 16'h5a5a;
         meas_index_o <= 1'b0;
      end else begin
         if (meas_req_i) begin
            mbusy <= 1'b1;
            mcnt <= slow_i ? 4'h9 : 4'h0;
         end else if (mbusy && mcnt == 4'h0) begin
            mbusy <= 1'b0;
            meas_ack_o <= 1'b1;
            meas_data_o <= 16'h0100 | 16'(meas_sel_i);
            meas_index_o <= index_en_i;
         end else if (mbusy) begin
            mcnt <= mcnt - 4'h1;
         end
         // Acks spaced apart so each storage category gets its own
         if (!store_req_i || store_ack_o) begin
            scnt <= slow_i ? 4'h7 : 4'h1;
         end else if (scnt == 4'h0) begin
            store_ack_o <= 1'b1;
         end else begin
            scnt <= scnt - 4'h1;
         end
      end
   end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the auto setup and direct drive block
`timescale 1ns/1ns
module tb_top;
   import mads_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] op_sel = 8'h00;
   logic [15:0] ctrl = 16'h0000;
   logic op_en = 1'b0, hall = 1'b0, idx_en = 1'b0, mism = 1'b0;
   logic slow = 1'b0, save = 1'b0, rst_cfg = 1'b0, en_in = 1'b0;
   logic clk_in = 1'b0, dir_in = 1'b0;
   logic [2:0] paddr = 3'h0;
   logic [11:0] adc = 12'h000;
   mads_cfg_t cfg = '0;
   logic m_ack, m_idx, m_req, s_req, s_ack, sl_ok;
   logic [15:0] m_data, status, pdata;
   logic [2:0] m_sel;
   logic [7:0] act_op, s_sub;
   mads_drive_t drv;
   int n_fail = 0, comparisons = 0, n_req = 0, cycles = 0;
   logic [15:0] sub_log = 16'h0000;

   // 100 MHz clock
   always #5 clock_i = ~clock_i;

   mads_core u_dut (.clock_i(clock_i), .reset_i(reset_i),
      .op_mode_sel_i(op_sel), .op_enabled_i(op_en), .ctrl_word_i(ctrl),
      .hall_fitted_i(hall), .meas_ack_i(m_ack), .meas_data_i(m_data),
      .meas_index_i(m_idx), .winding_mismatch_i(mism),
      .store_ack_i(s_ack), .param_addr_i(paddr), .spec_cfg_i(cfg),
      .save_app_i(save), .restart_i(rst_cfg), .enable_in_i(en_in),
      .clk_in_i(clk_in), .dir_in_i(dir_in), .adc_i(adc),
      .status_word_o(status), .active_op_mode_o(act_op),
      .meas_req_o(m_req), .meas_sel_o(m_sel), .store_req_o(s_req),
      .store_sub_o(s_sub), .param_data_o(pdata),
      .sensorless_ok_o(sl_ok), .drive_o(drv));

   mads_far_model u_far (.clock_i(clock_i), .reset_i(reset_i),
      .slow_i(slow), .index_en_i(idx_en), .meas_req_i(m_req),
      .meas_sel_i(m_sel), .store_req_i(s_req), .meas_ack_o(m_ack),
      .meas_data_o(m_data), .meas_index_o(m_idx), .store_ack_o(s_ack));

   // Request count, storage order as taken, and the hang limit
   always @(posedge clock_i) begin
      cycles++;
      if (m_req) n_req++;
      if (s_ack && s_req) sub_log = {sub_log[7:0], s_sub};
      if (cycles == 40000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Start with the drive not enabled must be ignored
   task automatic start_refused();
      op_sel = OPMODE_AUTOSETUP;
      op_en = 1'b0;
      n_req = 0;
      ctrl[CW_MODE_SPECIFIC_BIT] = 1'b1;
      tick(10);
      chk("no start", 16'h0, 16'(n_req));
      ctrl = 16'h0;
      tick(1);
   endtask

   // Full setup run: phase count, flags, storage order, stored value
   task automatic run_setup(input logic h, input logic ix, input logic mm);
      int w;
      hall = h;
      idx_en = ix;
      mism = mm;
      op_sel = OPMODE_AUTOSETUP;
      op_en = 1'b1;
      tick(3);
      chk("active mode", 16'(OPMODE_AUTOSETUP), 16'(act_op));
      n_req = 0;
      sub_log = 16'h0;
      ctrl[CW_MODE_SPECIFIC_BIT] = 1'b1;
      tick(2);
      chk("done clear", 16'h0, 16'(status[SW_SETUP_DONE_BIT]));
      w = 0;
      while (status[SW_SETUP_DONE_BIT] !== 1'b1 && w < 400) begin
         tick(1);
         w++;
      end
      chk("done", 16'h1, 16'(status[SW_SETUP_DONE_BIT]));
      chk("requests", 16'(4 + h), 16'(n_req));
      chk("index", 16'(ix), 16'(status[SW_INDEX_FOUND_BIT]));
      chk("sensorless", 16'(!mm), 16'(sl_ok));
      chk("store order", 16'h0506, sub_log);
      chk("status rest", 16'h0, status & 16'hebff);
      chk("last phase", 16'(3 + h), 16'(m_sel));
      paddr = 3'h2;
      tick(2);
      chk("stored", 16'h0102, pdata);
      ctrl = 16'h0;
   endtask

   // Losing operation enabled mid-run must never report completion
   task automatic abort_run();
      op_en = 1'b1;
      tick(2);
      ctrl[CW_MODE_SPECIFIC_BIT] = 1'b1;
      tick(4);
      op_en = 1'b0;
      tick(30);
      chk("aborted", 16'h0, 16'(status[SW_SETUP_DONE_BIT]));
      ctrl = 16'h0;
   endtask

   // Expected speed from the voltage mapping with its dead zones
   function automatic logic [15:0] exp_spd(input int a, input bit joy,
                                           input int mx, input bit d);
      int v;
      v = joy ? a - 2047 : a;
      if (joy ? (v <= 8 && v >= -8) : a <= 8) return 16'h0;
      v = joy ? v * mx / 2047 : a * mx / 4095;
      return 16'(d ? -v : v);
   endfunction

   task automatic set_mode(input logic [7:0] a, input logic [3:0] m,
                           input logic rs);
      cfg = '{activate: a, mode: m};
      save = 1'b1;
      tick(1);
      save = 1'b0;
      rst_cfg = rs;
      tick(1);
      rst_cfg = 1'b0;
      tick(4);
   endtask

   task automatic chk_adc(input logic [11:0] a, input bit j, input int mx,
                          input bit d);
      adc = a;
      dir_in = d;
      tick(4);
      chk("speed", exp_spd(int'(a), j, mx, d), drv.target_vel);
   endtask

   // Every special mode value, with enable on and then off
   task automatic mode_sweep();
      logic [3:0] m;
      int mx;
      for (int i = 0; i < 16; i++) begin
         m = 4'(i);
         mx = m[0] ? 100 : 1000;
         en_in = 1'b1;
         dir_in = 1'b0;
         adc = 12'hfff;
         set_mode(SPECIAL_ACTIVATE, m, 1'b1);
         chk("closed", 16'(m[3]), 16'(drv.closed_loop));
         chk("op", m[2] ? 16'h02 : 16'hff, 16'(drv.op_mode));
         chk("motion", 16'h1, 16'(drv.motion_en));
         if (m[2]) chk("scale", 16'(mx), drv.vel_scale);
         case (m[2:1])
            KIND_CLKDIR: begin
               clk_in = 1'b1;
               dir_in = 1'b1;
               tick(2);
               chk("step", 16'h1, 16'(drv.step));
               chk("dir", 16'h1, 16'(drv.dir));
               clk_in = 1'b0;
               tick(2);
               chk("step low", 16'h0, 16'(drv.step));
            end
            KIND_TEST: begin
               chk("test", 16'(m[0] ? -30 : 30), drv.target_vel);
               chk("test dir", 16'(m[0]), 16'(drv.dir));
               chk("test run", 16'h1, 16'(drv.test_run));
            end
            KIND_ANALOG: begin
               chk_adc(12'hfff, 0, mx, 0);
               chk_adc(12'hfff, 0, mx, 1);
               chk_adc(12'h008, 0, mx, 0);
               chk_adc(12'h009, 0, mx, 0);
            end
            default: begin
               chk("offset", 16'(ADC_MID), 16'(drv.analog_offset));
               chk_adc(12'h7ff, 1, mx, 0);
               chk_adc(12'h000, 1, mx, 0);
               chk_adc(12'h807, 1, mx, 0);
               chk_adc(12'h808, 1, mx, 0);
               chk_adc(12'hfff, 1, mx, 0);
            end
         endcase
         en_in = 1'b0;
         tick(4);
         chk("motion off", 16'h0, 16'(drv.motion_en));
         chk("target off", 16'h0, drv.target_vel);
         chk("run off", 16'h0, 16'({drv.test_run, drv.step}));
      end
   endtask

   // Saved but not restarted config must leave the running mode alone
   task automatic no_restart();
      set_mode(SPECIAL_ACTIVATE, 4'h4, 1'b1);
      set_mode(8'h00, 4'h4, 1'b0);
      chk("kept", 16'(OPMODE_VELOCITY), 16'(drv.op_mode));
      set_mode(8'h00, 4'h4, 1'b1);
      chk("inactive", 16'(op_sel), 16'(drv.op_mode));
   endtask

   // Main sequence; inputs change only at falling edges
   initial begin
      tick(8);
      reset_i = 1'b0;
      chk("status rst", 16'h0, status);
      chk("sub rst", 16'(STORE_SUB_DRIVE), 16'(s_sub));
      start_refused();
      run_setup(1'b0, 1'b1, 1'b1);
      slow = 1'b1;
      run_setup(1'b1, 1'b0, 1'b0);
      slow = 1'b0;
      // Host restarts the device after setup; all status must clear
      reset_i = 1'b1;
      tick(2);
      reset_i = 1'b0;
      chk("restart", 16'h0, status);
      abort_run();
      op_sel = 8'h00;
      mode_sweep();
      no_restart();
      print_verdict();
   end
endmodule
